//--- src/lqm_consts.svh
// Register map, field positions and reset values of the link quality monitor
// How it works
// - Variance sum readable via 16-bit data word
// - Hold set by software blocks new variance loads
// - After hold: low half first, then high
// - Two consecutive reads clear hold and ready
// - Bit 15 enables monitor, needs 100 Mb link
// - Threshold at max or min disables check
// - Threshold violation raises interrupt when enabled
// - Control read clears warnings, re-arms interrupt
// - Bits 14..10 restart DSP per parameter
// - Restart also drops link if option 0
// - Warning bits 9..0 as high/low pairs
// - Warning bits read-only, clear on read
`ifndef LQM_CONSTS_SVH
`define LQM_CONSTS_SVH
`define IDX_VAR_CTRL    8'h1a
`define IDX_VAR_WORD    8'h1b
`define IDX_QMON_CTRL   8'h1d
`define IDX_INT_STAT    8'h20
`define IDX_INT_MASK    8'h21
`define VC_READY_BIT    15
`define VC_HOLD_BIT     3
`define VC_TIMER_LSB    1
`define VC_ENABLE_BIT   0
`define QM_ON_BIT       15
`define QM_RESTART_LSB  10
`define INT_QMON_BIT    0
`define INT_VAR_BIT     1
`define NUM_PARAMS      5
`define THR_RESET       8'h80
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10
`endif

//--- src/lqm_pkg.sv
// Types shared by the link quality monitor register logic
package lqm_pkg;
   typedef enum logic [0:0]
   {
      VR_IDLE     = 1'b0,
      VR_LOW_SENT = 1'b1
   } var_read_e;

   typedef struct packed {
      logic        aw_have;
      logic [7:0]  aw_idx;
      logic        w_have;
      logic [15:0] w_data;
      logic [1:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [15:0] rdata;
      logic [1:0]  rresp;
      logic [5:0]  ctl;
      logic [9:0]  warn;
      logic        disarmed;
      logic [31:0] var_sum;
      logic        var_ready;
      logic        var_hold;
      logic [1:0]  var_timer;
      logic        var_en;
      var_read_e   var_half;
      logic [1:0]  intr_stat;
      logic [1:0]  intr_mask;
      logic        dsp_restart;
      logic        link_drop;
   } regs_s;
endpackage

//--- src/link_quality_monitor_regs.sv
// Variance readout and link quality monitor registers on an AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
`include "lqm_consts.svh"

module link_quality_monitor_regs
   import lqm_pkg::*;
#(
   parameter int ADDR_W  = 8,
   parameter int PARAM_W = 8
)
(
   input  wire logic                       sys_clk,
   input  wire logic                       sys_rst,
   input  wire logic                       clk_en,
   input  wire logic [ADDR_W-1:0]          s_axi_awaddr,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   input  wire logic [31:0]                s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   output logic [1:0]                      s_axi_bresp,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   input  wire logic [ADDR_W-1:0]          s_axi_araddr,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   output logic [31:0]                     s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   input  wire logic                       link_100_ok,
   input  wire logic                       signal_detect_option,
   input  wire logic [31:0]                var_sum_in,
   input  wire logic                       var_sum_valid,
   input  wire logic [5*PARAM_W-1:0]       param_val,
   input  wire logic                       param_valid,
   input  wire logic [5*PARAM_W-1:0]       thr_high,
   input  wire logic [5*PARAM_W-1:0]       thr_low,
   output logic                            var_enable,
   output logic [1:0]                      var_timer_sel,
   output logic                            dsp_restart,
   output logic                            link_drop,
   output logic                            irq
);

   if (ADDR_W < 8 || ADDR_W > 32)
   begin : g_chk_addr
      $error("ADDR_W must be 8 to 32");
   end
   if (PARAM_W < 2 || PARAM_W > 16)
   begin : g_chk_param
      $error("PARAM_W must be 2 to 16");
   end

   localparam logic [PARAM_W-1:0] P_MAX = '1;
   localparam logic [PARAM_W-1:0] P_MIN = '0;

   regs_s       s_reg;
   regs_s       s_next;
   logic [9:0]  viol;
   logic [4:0]  viol_param;
   logic        mon_active;
   logic [7:0]  ar_idx;
   logic        rd_take;
   logic        ctl_read;
   logic        word_read;
   logic        wr_do;
   logic        ren_fire;

   // Parameter i: 0 equalizer, 1 gain, 2 wander, 3 freq offset, 4 freq control
   assign mon_active = s_reg.ctl[5] & link_100_ok;

   for (genvar i = 0; i < 5; i++)
   begin : g_cmp
      logic [PARAM_W-1:0] v;
      logic [PARAM_W-1:0] hi;
      logic [PARAM_W-1:0] lo;
      assign v  = param_val[i*PARAM_W +: PARAM_W];
      assign hi = thr_high[i*PARAM_W +: PARAM_W];
      assign lo = thr_low[i*PARAM_W +: PARAM_W];
      // Extreme thresholds can never be crossed in a meaningful way
      assign viol[2*i+1] = mon_active & param_valid & (hi != P_MAX) & (hi != P_MIN)
                           & (v > hi);
      assign viol[2*i]   = mon_active & param_valid & (lo != P_MAX) & (lo != P_MIN)
                           & (v < lo);
      assign viol_param[i] = viol[2*i+1] | viol[2*i];
   end

   assign s_axi_awready = clk_en & ~s_reg.aw_have & ~s_reg.bvalid;
   assign s_axi_wready  = clk_en & ~s_reg.w_have & ~s_reg.bvalid;
   assign s_axi_arready = clk_en & ~s_reg.rvalid;
   assign s_axi_bvalid  = s_reg.bvalid;
   assign s_axi_bresp   = s_reg.bresp;
   assign s_axi_rvalid  = s_reg.rvalid;
   assign s_axi_rresp   = s_reg.rresp;
   assign s_axi_rdata   = {16'h0000, s_reg.rdata};
   assign var_enable    = s_reg.var_en;
   assign var_timer_sel = s_reg.var_timer;
   assign dsp_restart   = s_reg.dsp_restart;
   assign link_drop     = s_reg.link_drop;
   assign irq           = |(s_reg.intr_stat & s_reg.intr_mask);

   assign ar_idx    = 8'(s_axi_araddr >> 2);
   assign rd_take   = s_axi_arvalid & s_axi_arready;
   assign ctl_read  = rd_take & (ar_idx == `IDX_QMON_CTRL);
   assign word_read = rd_take & (ar_idx == `IDX_VAR_WORD);
   assign wr_do     = clk_en & s_reg.aw_have & s_reg.w_have;
   assign ren_fire  = |(viol_param & s_reg.ctl[4:0]);

   always_comb
   begin
      s_next = s_reg;
      s_next.dsp_restart = 1'b0;
      s_next.link_drop   = 1'b0;

      if (s_axi_awvalid && s_axi_awready)
      begin
         s_next.aw_have = 1'b1;
         s_next.aw_idx  = 8'(s_axi_awaddr >> 2);
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         s_next.w_have = 1'b1;
         s_next.w_data = s_axi_wdata[15:0];
         s_next.w_strb = s_axi_wstrb[1:0];
      end
      if (s_reg.bvalid && s_axi_bready)
      begin
         s_next.bvalid = 1'b0;
      end
      if (s_reg.rvalid && s_axi_rready)
      begin
         s_next.rvalid = 1'b0;
      end

      if (wr_do)
      begin
         s_next.aw_have = 1'b0;
         s_next.w_have  = 1'b0;
         s_next.bvalid  = 1'b1;
         s_next.bresp   = `RESP_OKAY;
         case (s_reg.aw_idx)
            `IDX_VAR_CTRL:
            begin
               if (s_reg.w_strb[0])
               begin
                  s_next.var_hold  = s_reg.w_data[`VC_HOLD_BIT];
                  s_next.var_timer = s_reg.w_data[`VC_TIMER_LSB +: 2];
                  s_next.var_en    = s_reg.w_data[`VC_ENABLE_BIT];
                  s_next.var_half  = VR_IDLE;
               end
            end
            `IDX_QMON_CTRL:
            begin
               if (s_reg.w_strb[1])
               begin
                  s_next.ctl = s_reg.w_data[`QM_RESTART_LSB +: 6];
               end
            end
            `IDX_INT_STAT:
            begin
               if (s_reg.w_strb[0])
               begin
                  s_next.intr_stat = s_reg.intr_stat & ~s_reg.w_data[1:0];
               end
            end
            `IDX_INT_MASK:
            begin
               if (s_reg.w_strb[0])
               begin
                  s_next.intr_mask = s_reg.w_data[1:0];
               end
            end
            `IDX_VAR_WORD:
            begin
               s_next.bresp = `RESP_OKAY;
            end
            default:
            begin
               s_next.bresp = `RESP_SLVERR;
            end
         endcase
      end

      if (rd_take)
      begin
         s_next.rvalid = 1'b1;
         s_next.rresp  = `RESP_OKAY;
         s_next.rdata  = 16'h0000;
         // Any other read breaks the low/high pairing
         s_next.var_half = VR_IDLE;
         case (ar_idx)
            `IDX_VAR_CTRL:
            begin
               s_next.rdata = {s_reg.var_ready, 11'h000, s_reg.var_hold,
                               s_reg.var_timer, s_reg.var_en};
            end
            `IDX_VAR_WORD:
            begin
               if (s_reg.var_hold && s_reg.var_half == VR_LOW_SENT)
               begin
                  s_next.rdata     = s_reg.var_sum[31:16];
                  s_next.var_hold  = 1'b0;
                  s_next.var_ready = 1'b0;
               end
               else
               begin
                  s_next.rdata = s_reg.var_sum[15:0];
                  if (s_reg.var_hold)
                  begin
                     s_next.var_half = VR_LOW_SENT;
                  end
               end
            end
            `IDX_QMON_CTRL:
            begin
               s_next.rdata    = {s_reg.ctl, s_reg.warn};
               s_next.warn     = 10'h000;
               s_next.disarmed = 1'b0;
            end
            `IDX_INT_STAT:
            begin
               s_next.rdata = {14'h0000, s_reg.intr_stat};
            end
            `IDX_INT_MASK:
            begin
               s_next.rdata = {14'h0000, s_reg.intr_mask};
            end
            default:
            begin
               s_next.rresp = `RESP_SLVERR;
            end
         endcase
      end

      // Sets come after clears so that a same-cycle event is never lost
      if (var_sum_valid && !s_next.var_hold)
      begin
         s_next.var_sum   = var_sum_in;
         s_next.var_ready = 1'b1;
         s_next.intr_stat[`INT_VAR_BIT] = 1'b1;
      end
      s_next.warn = s_next.warn | viol;
      if (|viol && !s_next.disarmed)
      begin
         s_next.intr_stat[`INT_QMON_BIT] = 1'b1;
         s_next.disarmed = 1'b1;
      end
      // Restart pulses on every clk_en cycle with a restart-enabled violation; the DSP side must accept back-to-back pulses
      if (ren_fire)
      begin
         s_next.dsp_restart = 1'b1;
         s_next.link_drop   = ~signal_detect_option;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         s_reg <= '0;
      end
      else if (clk_en)
      begin
         s_reg <= s_next;
      end
   end

   // Every attempt is gated by clk_en, so a frozen block can never trip a check
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   a_hold_blocks_load: assert property (
      clk_en && s_reg.var_hold && !rd_take && !wr_do |=> $stable(s_reg.var_sum))
      else $error("variance sum changed while held");

   a_low_half_first: assert property (
      word_read && s_reg.var_hold && s_reg.var_half == VR_IDLE
      |=> s_axi_rvalid && s_axi_rdata == {16'h0000, $past(s_reg.var_sum[15:0])})
      else $error("first held read did not give the low half");

   // A load landing on the second read sets ready again, since set wins over clear
   a_pair_clears: assert property (
      word_read && s_reg.var_hold && s_reg.var_half == VR_LOW_SENT && !wr_do && !var_sum_valid
      |=> !s_reg.var_hold && !s_reg.var_ready
          && s_axi_rdata == {16'h0000, $past(s_reg.var_sum[31:16])})
      else $error("second held read did not return high half and clear");

   a_idle_no_warn: assert property (
      clk_en && !mon_active && !ctl_read
      |=> (s_reg.warn & ~$past(s_reg.warn)) == 10'h000)
      else $error("warning set while monitor inactive");

   a_hi_bound_off: assert property (
      clk_en && !ctl_read && !s_reg.warn[1]
      && (thr_high[PARAM_W-1:0] == P_MAX || thr_high[PARAM_W-1:0] == P_MIN) |=> !s_reg.warn[1])
      else $error("disabled high threshold still flagged");

   a_lo_bound_off: assert property (
      clk_en && !ctl_read && !s_reg.warn[0]
      && (thr_low[PARAM_W-1:0] == P_MAX || thr_low[PARAM_W-1:0] == P_MIN) |=> !s_reg.warn[0])
      else $error("disabled low threshold still flagged");

   a_event_irq: assert property (
      clk_en && |viol && !s_reg.disarmed && s_reg.intr_mask[0] && !wr_do |=> irq)
      else $error("unmasked violation gave no interrupt");

   a_read_rearms: assert property (
      ctl_read && viol == 10'h000 |=> s_reg.warn == 10'h000 && !s_reg.disarmed)
      else $error("control read did not clear and re-arm");

   a_restart_cause: assert property (
      $past(clk_en) && dsp_restart |-> $past(|(viol_param & s_reg.ctl[4:0])))
      else $error("restart without an enabled violation");

   a_drop_option: assert property (
      clk_en && ren_fire |=> dsp_restart && (link_drop == !$past(signal_detect_option)))
      else $error("link drop does not follow the option bit");

   a_once_per_arm: assert property (
      clk_en && s_reg.disarmed && !ctl_read && !wr_do
      |=> $stable(s_reg.intr_stat[0]))
      else $error("monitor interrupt set again before re-arm");

   a_warn_sticky: assert property (
      clk_en && !ctl_read |=> (s_reg.warn & $past(s_reg.warn)) == $past(s_reg.warn))
      else $error("warning cleared without a control read");

   a_warn_sets: assert property (
      clk_en && viol != 10'h000 |=> (s_reg.warn & $past(viol)) == $past(viol))
      else $error("violation did not raise its warning bit");

   a_load_sets_ready: assert property (
      clk_en && var_sum_valid && !s_reg.var_hold && !wr_do
      |=> s_reg.var_ready && s_reg.var_sum == $past(var_sum_in))
      else $error("unheld variance load did not set ready");

   a_restart_needs_enable: assert property (
      clk_en && !ren_fire |=> !dsp_restart && !link_drop)
      else $error("restart or link drop without an enabled violation");

endmodule
`default_nettype wire

//--- dv/tb_top.sv
// Self-checking bench for the link quality monitor register block
`timescale 1ns/1ps
`default_nettype none
`include "lqm_consts.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_total++; \
   $display("[FAIL] %0t mismatch at line %0d: got %h", $time, `__LINE__, a); end end

module tb_top;
   import lqm_pkg::*;
   logic        sys_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, var_sum_in = 32'h0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, var_timer_sel;
   logic        link_100_ok = 1'b1, signal_detect_option = 1'b0, var_sum_valid = 1'b0;
   logic [39:0] param_val = {5{8'h20}};
   logic        param_valid = 1'b0;
   logic        clk_en = 1'b1;
   // Slot 0 has both bounds at the disabling extremes
   logic [39:0] thr_high = {{4{8'h40}}, 8'h00};
   logic [39:0] thr_low  = {{4{8'h10}}, 8'hff};
   logic        var_enable, dsp_restart, link_drop, irq;
   int          err_total = 0;
   int          comparisons = 0;
   logic [15:0] rd;
   logic [1:0]  rsp;

   always #25 sys_clk = ~sys_clk;

   link_quality_monitor_regs DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .link_100_ok(link_100_ok),
      .signal_detect_option(signal_detect_option), .var_sum_in(var_sum_in),
      .var_sum_valid(var_sum_valid), .param_val(param_val), .param_valid(param_valid),
      .thr_high(thr_high), .thr_low(thr_low), .var_enable(var_enable),
      .var_timer_sel(var_timer_sel), .dsp_restart(dsp_restart), .link_drop(link_drop), .irq(irq));

   task automatic stop_test();
      if (err_total == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Handshakes are judged at the falling edge, where combinational readies have settled
   task automatic wr(input logic [7:0] idx, input logic [15:0] d);
      logic aw_p, w_p, b_ok;
      aw_p = 1'b1;
      w_p = 1'b1;
      @(posedge sys_clk);
      s_axi_awaddr <= {idx[5:0], 2'b00};
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= {16'h0000, d};
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (aw_p | w_p)
      begin
         @(negedge sys_clk);
         if (s_axi_awvalid & s_axi_awready) aw_p = 1'b0;
         if (s_axi_wvalid & s_axi_wready) w_p = 1'b0;
         @(posedge sys_clk);
         if (!aw_p) s_axi_awvalid <= 1'b0;
         if (!w_p) s_axi_wvalid <= 1'b0;
      end
      do
      begin
         @(negedge sys_clk);
         b_ok = s_axi_bvalid;
         rsp = s_axi_bresp;
         @(posedge sys_clk);
      end while (!b_ok);
      s_axi_bready <= 1'b0;
   endtask

   task automatic rdr(input logic [7:0] idx);
      logic ar_p, r_ok;
      ar_p = 1'b1;
      @(posedge sys_clk);
      s_axi_araddr <= {idx[5:0], 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(negedge sys_clk);
         if (s_axi_arvalid & s_axi_arready) ar_p = 1'b0;
         r_ok = s_axi_rvalid;
         rd = s_axi_rdata[15:0];
         rsp = s_axi_rresp;
         @(posedge sys_clk);
         if (!ar_p) s_axi_arvalid <= 1'b0;
      end while (!r_ok);
      s_axi_rready <= 1'b0;
   endtask

   // One compare cycle on a slot, then the pulse outputs one cycle later
   task automatic mon(input int s, input logic [7:0] v, input logic er, input logic ed);
      @(posedge sys_clk);
      param_val[s*8 +: 8] <= v;
      param_valid <= 1'b1;
      @(posedge sys_clk);
      param_valid <= 1'b0;
      param_val <= {5{8'h20}};
      #1;
      `CHK(dsp_restart, er)
      `CHK(link_drop, ed)
   endtask

   initial
   begin
      #1ms;
      err_total++;
      stop_test();
   end

   initial
   begin
      repeat (12) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rdr(`IDX_VAR_CTRL); `CHK(rd, 16'h0000)
      rdr(`IDX_QMON_CTRL); `CHK(rd, 16'h0000)
      rdr(`IDX_VAR_WORD); `CHK(rd, 16'h0000)
      rdr(8'h10); `CHK(rsp, `RESP_SLVERR)
      wr(8'h10, 16'hffff); `CHK(rsp, `RESP_SLVERR)
      // Variance snapshot, then a load attempt while held
      @(posedge sys_clk);
      var_sum_in <= 32'h1234_5678;
      var_sum_valid <= 1'b1;
      @(posedge sys_clk);
      var_sum_valid <= 1'b0;
      rdr(`IDX_VAR_CTRL); `CHK(rd, 16'h8000)
      rdr(`IDX_INT_STAT); `CHK(rd, 16'h0002)
      `CHK(irq, 1'b0)
      wr(`IDX_VAR_CTRL, 16'h000f); `CHK(rsp, `RESP_OKAY)
      `CHK(var_enable, 1'b1)
      `CHK(var_timer_sel, 2'b11)
      @(posedge sys_clk);
      var_sum_in <= 32'hdead_beef;
      var_sum_valid <= 1'b1;
      @(posedge sys_clk);
      var_sum_valid <= 1'b0;
      rdr(`IDX_VAR_WORD); `CHK(rd, 16'h5678)
      rdr(`IDX_VAR_WORD); `CHK(rd, 16'h1234)
      rdr(`IDX_VAR_CTRL); `CHK(rd, 16'h0007)
      wr(`IDX_INT_STAT, 16'h0003);
      // Monitor on with restart on frequency control only
      wr(`IDX_QMON_CTRL, 16'hc000);
      wr(`IDX_INT_MASK, 16'h0001);
      rdr(`IDX_INT_MASK); `CHK(rd, 16'h0001)
      mon(4, 8'h50, 1'b1, 1'b1);
      `CHK(irq, 1'b1)
      @(posedge sys_clk);
      #1;
      `CHK(dsp_restart, 1'b0)
      wr(`IDX_INT_STAT, 16'h0001);
      `CHK(irq, 1'b0)
      mon(1, 8'h05, 1'b0, 1'b0);
      `CHK(irq, 1'b0)
      mon(0, 8'h50, 1'b0, 1'b0);
      mon(0, 8'h05, 1'b0, 1'b0);
      rdr(`IDX_QMON_CTRL); `CHK(rd, 16'hc204)
      rdr(`IDX_QMON_CTRL); `CHK(rd, 16'hc000)
      wr(`IDX_QMON_CTRL, 16'hc3ff);
      rdr(`IDX_QMON_CTRL); `CHK(rd, 16'hc000)
      mon(3, 8'h05, 1'b0, 1'b0);
      `CHK(irq, 1'b1)
      wr(`IDX_INT_STAT, 16'h0001);
      rdr(`IDX_QMON_CTRL); `CHK(rd, 16'hc040)
      // All restart enables, link kept because the option bit is set
      signal_detect_option <= 1'b1;
      wr(`IDX_QMON_CTRL, 16'hfc00);
      for (int s = 1; s < 5; s++)
      begin
         mon(s, 8'h50, 1'b1, 1'b0);
         rdr(`IDX_QMON_CTRL); `CHK(rd, 16'hfc00 | (16'h0001 << (2*s+1)))
      end
      // Frozen block: a violation must leave no pulse, no flag and no open bus slot
      clk_en <= 1'b0;
      mon(4, 8'h50, 1'b0, 1'b0);
      `CHK(s_axi_arready, 1'b0)
      @(posedge sys_clk);
      clk_en <= 1'b1;
      rdr(`IDX_QMON_CTRL); `CHK(rd, 16'hfc00)
      link_100_ok <= 1'b0;
      mon(4, 8'h50, 1'b0, 1'b0);
      rdr(`IDX_QMON_CTRL); `CHK(rd, 16'hfc00)
      link_100_ok <= 1'b1;
      wr(`IDX_QMON_CTRL, 16'h7c00);
      mon(4, 8'h50, 1'b0, 1'b0);
      rdr(`IDX_QMON_CTRL); `CHK(rd, 16'h7c00)
      stop_test();
   end
endmodule
`default_nettype wire
